// >>> fcq_ack_build.sv
// acknowledgement control field builder
`timescale 1ns/1ns
`include "fcq_defines.svh"
module fcq_ack_build (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [23:0] i_data_ctl,
  input wire logic [23:0] i_ack_base,
  input wire logic [3:0] i_confirm,
  input wire logic [1:0] i_abort_cond,
  output logic [23:0] o_ack_ctl,
  output logic o_ack_vld
);
  logic [23:0] ack_ctl; // registered acknowledgement field
  logic ack_vld; // one-cycle valid
  logic [23:0] next_ack_ctl;
  logic next_ack_vld;
  logic [3:0] ech; // echoed bits 19..16 after confirm/deny

  // compose the answer from the data frame and the recipient's decisions
  always_comb begin
    next_ack_ctl = i_ack_base;
    next_ack_vld = i_go;
    // echo each indication anded with its confirm bit
    ech = i_data_ctl[`FCQ_B_ENDS:`FCQ_B_INIT] & i_confirm;
    // abort request on a last+initiative frame denies both
    if (i_abort_cond == `FCQ_ABT_ABORT && i_data_ctl[`FCQ_B_ENDS] && i_data_ctl[`FCQ_B_INIT]) begin
      ech[3] = 1'b0;
      ech[0] = 1'b0;
    end
    next_ack_ctl[`FCQ_B_ENDS:`FCQ_B_INIT] = ech;
    // context bits inverted from the data frame
    next_ack_ctl[`FCQ_B_XCTX] = ~i_data_ctl[`FCQ_B_XCTX];
    next_ack_ctl[`FCQ_B_SCTX] = ~i_data_ctl[`FCQ_B_SCTX];
    next_ack_ctl[`FCQ_B_ABT_HI:`FCQ_B_ABT_LO] = i_abort_cond;
    if (!i_go) begin
      next_ack_ctl = ack_ctl;
    end
  end

  // register the answer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_ctl <= `FCQ_ZERO24;
      ack_vld <= 1'b0;
    end else begin
      ack_ctl <= next_ack_ctl;
      ack_vld <= next_ack_vld;
    end
  end

  assign o_ack_ctl = ack_ctl;
  assign o_ack_vld = ack_vld;

  ack_ctx_inv_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_go |=> o_ack_ctl[23:22] == ~$past(i_data_ctl[23:22]))
    else $error("context bits not inverted");
  ack_abort_deny_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_go && i_abort_cond == 2'h1 && i_data_ctl[19] && i_data_ctl[16]) |=> (!o_ack_ctl[19] && !o_ack_ctl[16]))
    else $error("abort did not deny end and initiative");
  ack_echo_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_go && i_abort_cond != 2'h1) |=> o_ack_ctl[19:16] == $past(i_data_ctl[19:16] & i_confirm))
    else $error("echo bits wrong");
endmodule

// >>> fcq_defines.svh
// bit positions, field values and reset values for the frame control qualifier
`ifndef FCQ_DEFINES_SVH
`define FCQ_DEFINES_SVH
`define FCQ_W 24
`define FCQ_B_XCTX 23
`define FCQ_B_SCTX 22
`define FCQ_B_FSEQ 21
`define FCQ_B_LSEQ 20
`define FCQ_B_ENDS 19
`define FCQ_B_ENDC 18
`define FCQ_B_CHAIN 17
`define FCQ_B_INIT 16
`define FCQ_B_XREA 15
`define FCQ_B_XREB 14
`define FCQ_B_RETX 9
`define FCQ_B_B8 8
`define FCQ_B_CSC_HI 7
`define FCQ_B_CSC_LO 6
`define FCQ_B_ABT_HI 5
`define FCQ_B_ABT_LO 4
`define FCQ_B_RO 3
`define FCQ_B_FILL_HI 1
`define FCQ_B_FILL_LO 0
`define FCQ_ABT_CONT 2'h0
`define FCQ_ABT_ABORT 2'h1
`define FCQ_ABT_STOP 2'h2
`define FCQ_ABT_RETX 2'h3
`define FCQ_ZERO24 24'h000000
`endif

// >>> fcq_pkg.sv
// types for the frame control qualifier
package fcq_pkg;
  // frame kind: data frame or acknowledgement/busy/reject
  typedef enum logic [1:0] {
    FCQ_DATA = 2'h1,
    FCQ_LINK = 2'h2
  } fcq_kind_t;
  // action requested by the abort-condition field of an acknowledgement
  typedef enum logic [3:0] {
    FCQ_ACT_CONT = 4'h1,
    FCQ_ACT_ABORT = 4'h2,
    FCQ_ACT_STOP = 4'h4,
    FCQ_ACT_RETX = 4'h8
  } fcq_act_t;
  // reassignment tracker states
  typedef enum logic [1:0] {
    FCQ_XR_OPEN = 2'h1,
    FCQ_XR_DONE = 2'h2
  } fcq_xr_t;
endpackage

// >>> fcq_qualifier.sv
// frame control field qualifier: valid mask per received frame, and ack builder
`timescale 1ns/1ns
`include "fcq_defines.svh"
module fcq_qualifier (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_frame_vld, // one-cycle strobe of a received frame
  input wire logic i_frame_is_link, // 1: ack/busy/reject, 0: data
  input wire logic i_first, // frame is first of sequence
  input wire logic i_last, // frame is last of sequence
  input wire logic i_connect_req, // frame is a connect-request
  input wire logic [23:0] i_frame_control_field,
  input wire logic i_xid_reassign_en, // login-negotiated reassignment
  input wire logic i_seq_start, // new sequence begins, rearms trackers
  input wire logic i_ack_rcvd, // an ack for our sequence arrived
  input wire logic i_recip_xid_seen, // recipient id seen in a data frame
  input wire logic i_ack_go, // build one acknowledgement
  input wire logic [23:0] i_ack_data_ctl, // field of the frame answered
  input wire logic [23:0] i_ack_base, // other fields of the answer
  input wire logic [3:0] i_ack_confirm, // confirm 19..16
  input wire logic [1:0] i_ack_abort_cond,
  output logic o_mask_vld,
  output logic [23:0] o_valid_mask,
  output logic [23:0] o_qual_field, // field anded with mask
  output logic [3:0] o_ack_action, // decoded abort field of an ack
  output logic [23:0] o_ack_ctl,
  output logic o_ack_vld
);
  fcq_pkg::fcq_xr_t data_xr; // data reassign tracker
  fcq_pkg::fcq_xr_t ack_xr; // ack reassign tracker
  fcq_pkg::fcq_xr_t next_data_xr;
  fcq_pkg::fcq_xr_t next_ack_xr;
  logic mask_vld;
  logic [23:0] valid_mask;
  logic [23:0] qual_field;
  logic [3:0] ack_action;
  logic next_mask_vld;
  logic [23:0] next_valid_mask;
  logic [23:0] next_qual_field;
  logic [3:0] next_ack_action;

  // decode an ack abort field to an action
  function automatic logic [3:0] abt_decode(input logic [1:0] f);
    case (f)
      `FCQ_ABT_CONT: abt_decode = fcq_pkg::FCQ_ACT_CONT;
      `FCQ_ABT_ABORT: abt_decode = fcq_pkg::FCQ_ACT_ABORT;
      `FCQ_ABT_STOP: abt_decode = fcq_pkg::FCQ_ACT_STOP;
      default: abt_decode = fcq_pkg::FCQ_ACT_RETX;
    endcase
  endfunction

  // reassignment trackers: rearmed on sequence start, closed by events
  always_comb begin
    next_data_xr = data_xr;
    next_ack_xr = ack_xr;
    case (data_xr)
      fcq_pkg::FCQ_XR_OPEN: begin
        if (i_ack_rcvd) begin
          next_data_xr = fcq_pkg::FCQ_XR_DONE;
        end
      end
      fcq_pkg::FCQ_XR_DONE: begin
        next_data_xr = fcq_pkg::FCQ_XR_DONE;
      end
      default: begin
        next_data_xr = fcq_pkg::FCQ_XR_OPEN;
      end
    endcase
    case (ack_xr)
      fcq_pkg::FCQ_XR_OPEN: begin
        if (i_recip_xid_seen) begin
          next_ack_xr = fcq_pkg::FCQ_XR_DONE;
        end
      end
      fcq_pkg::FCQ_XR_DONE: begin
        next_ack_xr = fcq_pkg::FCQ_XR_DONE;
      end
      default: begin
        next_ack_xr = fcq_pkg::FCQ_XR_OPEN;
      end
    endcase
    if (i_seq_start) begin
      next_data_xr = fcq_pkg::FCQ_XR_OPEN;
      next_ack_xr = fcq_pkg::FCQ_XR_OPEN;
    end
  end

  // valid mask computation
  always_comb begin
    logic [23:0] m;
    logic [23:0] f;
    logic first_q;
    logic last_q;
    logic xr_open;
    xr_open = 1'b0;
    m = `FCQ_ZERO24;
    f = i_frame_control_field;
    // a connect-request may carry first and last settings together
    first_q = i_first | i_connect_req;
    last_q = i_last | i_connect_req;
    if (!i_frame_is_link) begin
      // data frame
      m[`FCQ_B_XCTX] = 1'b1;
      m[`FCQ_B_SCTX] = 1'b1;
      m[`FCQ_B_FSEQ] = 1'b1;
      m[`FCQ_B_RETX] = 1'b1;
      m[`FCQ_B_RO] = 1'b1;
      m[`FCQ_B_FILL_HI] = 1'b1;
      m[`FCQ_B_FILL_LO] = 1'b1;
      m[`FCQ_B_B8] = first_q | last_q;
      m[`FCQ_B_ENDS] = last_q;
      m[`FCQ_B_INIT] = last_q;
      m[`FCQ_B_LSEQ] = last_q & f[`FCQ_B_ENDS];
      // bit 18 ignored unless 19 set
      m[`FCQ_B_ENDC] = last_q & f[`FCQ_B_ENDS];
      m[`FCQ_B_CSC_HI] = last_q & f[`FCQ_B_ENDS];
      m[`FCQ_B_CSC_LO] = last_q & f[`FCQ_B_ENDS];
      // chained only when 19=1, 18=0, 16=1 on last
      m[`FCQ_B_CHAIN] = last_q & f[`FCQ_B_ENDS] & ~f[`FCQ_B_ENDC] & f[`FCQ_B_INIT];
      // abort policy only on first data frame
      m[`FCQ_B_ABT_HI] = first_q;
      m[`FCQ_B_ABT_LO] = first_q;
      xr_open = (data_xr == fcq_pkg::FCQ_XR_OPEN);
      m[`FCQ_B_XREB] = last_q & f[`FCQ_B_ENDS];
    end else begin
      // acknowledgement, busy or reject
      m[`FCQ_B_XCTX] = 1'b1;
      m[`FCQ_B_SCTX] = 1'b1;
      m[`FCQ_B_FSEQ] = 1'b1;
      m[`FCQ_B_LSEQ] = 1'b1;
      m[`FCQ_B_ENDS] = 1'b1;
      m[`FCQ_B_ENDC] = f[`FCQ_B_ENDS];
      m[`FCQ_B_CHAIN] = 1'b1;
      m[`FCQ_B_INIT] = 1'b1;
      m[`FCQ_B_RETX] = 1'b1;
      m[`FCQ_B_B8] = 1'b1;
      m[`FCQ_B_CSC_HI] = last_q & f[`FCQ_B_ENDS];
      m[`FCQ_B_CSC_LO] = last_q & f[`FCQ_B_ENDS];
      // abort field on every ack
      m[`FCQ_B_ABT_HI] = 1'b1;
      m[`FCQ_B_ABT_LO] = 1'b1;
      xr_open = (ack_xr == fcq_pkg::FCQ_XR_OPEN);
      m[`FCQ_B_XREB] = last_q & f[`FCQ_B_ENDS];
    end
    m[`FCQ_B_XREA] = xr_open;
    // reassignment bits dead without login support
    if (!i_xid_reassign_en) begin
      m[`FCQ_B_XREA] = 1'b0;
      m[`FCQ_B_XREB] = 1'b0;
    end
    next_mask_vld = i_frame_vld;
    next_valid_mask = i_frame_vld ? m : valid_mask;
    next_qual_field = i_frame_vld ? (f & m) : qual_field;
    next_ack_action = ack_action;
    if (i_frame_vld && i_frame_is_link) begin
      next_ack_action = abt_decode(f[`FCQ_B_ABT_HI:`FCQ_B_ABT_LO]);
    end
  end

  // register trackers and outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      data_xr <= fcq_pkg::FCQ_XR_OPEN;
      ack_xr <= fcq_pkg::FCQ_XR_OPEN;
      mask_vld <= 1'b0;
      valid_mask <= `FCQ_ZERO24;
      qual_field <= `FCQ_ZERO24;
      ack_action <= 4'h0;
    end else begin
      data_xr <= next_data_xr;
      ack_xr <= next_ack_xr;
      mask_vld <= next_mask_vld;
      valid_mask <= next_valid_mask;
      qual_field <= next_qual_field;
      ack_action <= next_ack_action;
    end
  end

  assign o_mask_vld = mask_vld;
  assign o_valid_mask = valid_mask;
  assign o_qual_field = qual_field;
  assign o_ack_action = ack_action;

  // acknowledgement builder, registered inside
  fcq_ack_build u_ack (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_go(i_ack_go),
    .i_data_ctl(i_ack_data_ctl),
    .i_ack_base(i_ack_base),
    .i_confirm(i_ack_confirm),
    .i_abort_cond(i_ack_abort_cond),
    .o_ack_ctl(o_ack_ctl),
    .o_ack_vld(o_ack_vld)
  );

  no_xr_login_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_frame_vld && !i_xid_reassign_en) |=> o_valid_mask[15:14] == 2'h0)
    else $error("reassign bits valid without login support");
  endc_cond_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_frame_vld && !i_frame_control_field[19]) |=> !o_valid_mask[18])
    else $error("bit 18 valid without bit 19");
  ends_last_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_frame_vld && !i_frame_is_link) |=> o_valid_mask[19] == $past(i_last | i_connect_req))
    else $error("data bit 19 mask wrong");
  chain_cond_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_frame_vld && !i_frame_is_link) |=> o_valid_mask[17] == $past((i_last | i_connect_req)
      & i_frame_control_field[19] & !i_frame_control_field[18] & i_frame_control_field[16]))
    else $error("chain bit mask wrong");
  data_xr_close_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ack_rcvd && !i_seq_start) ##1 !i_seq_start ##1 (i_frame_vld && !i_frame_is_link && !i_seq_start)
      |=> !o_valid_mask[15])
    else $error("data reassign bit valid after ack");
  ack_xr_close_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_recip_xid_seen && !i_seq_start) ##1 !i_seq_start ##1 (i_frame_vld && i_frame_is_link && !i_seq_start)
      |=> !o_valid_mask[15])
    else $error("ack reassign bit valid after id seen");
  abt_first_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_frame_vld && !i_frame_is_link) |=> o_valid_mask[5:4] == {2{$past(i_first | i_connect_req)}})
    else $error("data abort mask wrong");
  abt_ack_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_frame_vld && i_frame_is_link) |=> (o_valid_mask[5:4] == 2'h3 && $onehot(o_ack_action)))
    else $error("ack abort field not evaluated");
  qual_and_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_mask_vld |-> o_qual_field == ($past(i_frame_control_field) & o_valid_mask))
    else $error("qualified field has masked bits");
  cov_data_last_c: cover property (@(posedge i_mclk) i_frame_vld && !i_frame_is_link && i_last);
  cov_ack_abort_c: cover property (@(posedge i_mclk) i_frame_vld && i_frame_is_link
    && i_frame_control_field[5:4] == 2'h1);
  cov_ack_build_c: cover property (@(posedge i_mclk) i_ack_go && i_ack_abort_cond == 2'h1);
endmodule

// >>> fcq_qualifier_tb.sv
// self-checking bench for the frame control qualifier
`timescale 1ns/1ns
module fcq_qualifier_tb;
  logic i_mclk = 1'b0; // 50 MHz clock
  logic rst = 1'b1; // sync reset
  logic xr = 1'b1; // login reassignment support
  logic seq_start = 1'b0, ack_rcvd = 1'b0, recip = 1'b0; // tracker events
  logic go = 1'b0; // ack build strobe
  logic [23:0] a_data = 24'h0, a_base = 24'h0; // ack inputs
  logic [3:0] a_conf = 4'h0;
  logic [1:0] a_abt = 2'h0;
  logic f_vld, f_link, f_first, f_last, f_conn; // frame from partner
  logic [23:0] f_field;
  logic o_mask_vld, o_ack_vld;
  logic [23:0] o_valid_mask, o_qual_field, o_ack_ctl;
  logic [3:0] o_ack_action;
  int mismatches = 0, n_tests = 0, cyc = 0;
  logic [23:0] fl [4] = '{24'hffffff, 24'h0b0010, 24'h0d0020, 24'h000000}; // field table
  always #10 i_mclk = ~i_mclk;
  fcq_remote_port rp_u (.i_mclk(i_mclk), .o_frame_vld(f_vld), .o_is_link(f_link), .o_first(f_first),
    .o_last(f_last), .o_conn(f_conn), .o_field(f_field));
  fcq_qualifier dut_u (.i_mclk(i_mclk), .i_rst(rst), .i_frame_vld(f_vld), .i_frame_is_link(f_link),
    .i_first(f_first), .i_last(f_last), .i_connect_req(f_conn), .i_frame_control_field(f_field),
    .i_xid_reassign_en(xr), .i_seq_start(seq_start), .i_ack_rcvd(ack_rcvd), .i_recip_xid_seen(recip),
    .i_ack_go(go), .i_ack_data_ctl(a_data), .i_ack_base(a_base), .i_ack_confirm(a_conf),
    .i_ack_abort_cond(a_abt), .o_mask_vld(o_mask_vld), .o_valid_mask(o_valid_mask),
    .o_qual_field(o_qual_field), .o_ack_action(o_ack_action), .o_ack_ctl(o_ack_ctl), .o_ack_vld(o_ack_vld));
  // compare and count
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // counts, verdict, end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // expected meaningful bits of a frame
  function automatic logic [23:0] exp_mask(input logic link, fi, la, input logic [23:0] f, input logic op);
    logic [23:0] m;
    if (!link) begin
      m = 24'he0020b;
      m[8] = fi | la;
      if (la) {m[19], m[16]} = 2'h3;
      if (la & f[19]) m = m | 24'h1440c0;
      if (la & f[19] & ~f[18] & f[16]) m[17] = 1'b1;
      if (fi) m[5:4] = 2'h3;
    end else begin
      m = 24'hfb0330;
      m[18] = f[19];
      if (la & f[19]) m = m | 24'h0040c0;
    end
    m[15] = op;
    if (!xr) m[15:14] = 2'h0;
    return m;
  endfunction
  // one frame through the partner, then judge the registered answer
  task automatic frame(input logic link, input logic [2:0] pos, input logic [23:0] f, input logic op);
    logic [23:0] m;
    rp_u.send(link, pos, f);
    #1;
    // expectation taken once the login support level has settled
    m = exp_mask(link, pos[2] | pos[0], pos[1] | pos[0], f, op);
    check("mask_vld", {23'h0, o_mask_vld}, 24'h1);
    check("valid_mask", o_valid_mask, m);
    check("qual_field", o_qual_field, f & m);
  endtask
  // tracker event pulse: {seq_start, ack_rcvd, recip}
  task automatic pulse(input logic [2:0] w);
    @(posedge i_mclk);
    {seq_start, ack_rcvd, recip} <= w;
    @(posedge i_mclk);
    {seq_start, ack_rcvd, recip} <= 3'h0;
  endtask
  // reassignment windows close and rearm
  task automatic t_track;
    pulse(3'h4);
    frame(1'b1, 3'h0, 24'h000020, 1'b1);
    frame(1'b0, 3'h0, 24'hffffff, 1'b1);
    pulse(3'h2);
    frame(1'b0, 3'h0, 24'hffffff, 1'b0);
    check("act_hold", {20'h0, o_ack_action}, 24'h4);
    frame(1'b1, 3'h0, 24'hffffff, 1'b1);
    pulse(3'h1);
    frame(1'b1, 3'h0, 24'hffffff, 1'b0);
    pulse(3'h6);
    frame(1'b0, 3'h0, 24'hffffff, 1'b1);
    frame(1'b1, 3'h0, 24'hffffff, 1'b1);
  endtask
  // link frames at all four first/last positions without connect-request, all four abort codes
  task automatic t_link;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 4; k++) begin
        frame(1'b1, {p[1:0], 1'b0}, fl[k], 1'b1);
        check("ack_action", {20'h0, o_ack_action}, 24'h1 << fl[k][5:4]);
      end
    end
  endtask
  // data frames at every position, with and without reassignment support
  task automatic t_data;
    for (int x = 1; x >= 0; x--) begin
      @(posedge i_mclk);
      xr <= x[0];
      for (int p = 0; p < 8; p++) begin
        for (int k = 0; k < 4; k++) frame(1'b0, p[2:0], fl[k], 1'b1);
      end
    end
  endtask
  // acknowledgement builder over abort codes and confirm patterns
  task automatic t_ack;
    logic [23:0] d, e;
    for (int i = 0; i < 16; i++) begin
      d = i[0] ? 24'hc90000 : 24'h4e0000;
      @(posedge i_mclk);
      go <= 1'b1;
      a_data <= d;
      a_base <= 24'h5a5a5a;
      a_conf <= i[1] ? 4'hf : 4'ha;
      a_abt <= i[3:2];
      e = 24'h5a5a5a;
      e[23:22] = ~d[23:22];
      e[19:16] = d[19:16] & (i[1] ? 4'hf : 4'ha);
      if (i[3:2] == 2'h1 && d[19] && d[16]) {e[19], e[16]} = 2'h0;
      e[5:4] = i[3:2];
      @(posedge i_mclk);
      go <= 1'b0;
      #1;
      check("ack_vld", {23'h0, o_ack_vld}, 24'h1);
      check("ack_ctl", o_ack_ctl, e);
      @(posedge i_mclk);
      #1;
      check("ack_vld_low", {23'h0, o_ack_vld}, 24'h0);
    end
  endtask
  // hang guard
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    rst <= 1'b0;
    #1;
    check("rst_mask_vld", {23'h0, o_mask_vld}, 24'h0);
    check("rst_action", {20'h0, o_ack_action}, 24'h0);
    check("rst_ack_vld", {23'h0, o_ack_vld}, 24'h0);
    t_track();
    t_link();
    t_data();
    t_ack();
    wrap_up();
  end
endmodule

// >>> fcq_remote_port.sv
// remote port model: presents received frames to the qualifier
`timescale 1ns/1ns
module fcq_remote_port (
  input wire logic i_mclk,
  output logic o_frame_vld,
  output logic o_is_link,
  output logic o_first,
  output logic o_last,
  output logic o_conn,
  output logic [23:0] o_field
);
  // idle link at time zero
  initial begin
    o_frame_vld = 1'b0;
    o_is_link = 1'b0;
    {o_first, o_last, o_conn} = 3'h0;
    o_field = 24'h000000;
  end
  // one frame strobe; afterwards position and field turn to their inverse so stale data never helps
  task automatic send(input logic link, input logic [2:0] pos, input logic [23:0] f);
    @(posedge i_mclk);
    o_frame_vld <= 1'b1;
    o_is_link <= link;
    {o_first, o_last, o_conn} <= pos;
    o_field <= f;
    @(posedge i_mclk);
    o_frame_vld <= 1'b0;
    {o_first, o_last, o_conn} <= ~pos;
    o_field <= ~f;
  endtask
endmodule
